// *** ltp_txd_protect.sv ***
// Transmit line protection: stuck-low timeout, gated and debounced short detection, APB slave.
// Assumes pclk at 10 MHz, MCU and transceiver signals asynchronous, power state from system logic.
//
// The implementer's own choice: register access over APB.
`include "ltp_defines.svh"

// Overview of operation
// R01: Stuck-low timing runs only in the full-power state.
// R02: The MCU never holds transmit low beyond 9 ms.
// R03: Transmit low continuously for 10.24 ms is a timeout.
// R04: Timeout sets latched stuck flag forcing transmit high, and interrupt flag bit 2.
// R05: Stuck flag shows in status bit 2, survives interrupt flag read.
// R06: Writing 1 to config bit 4 clears the stuck flag.
// R07: Nonzero delay: gate opens after transmit low, receive high for delay ticks.
// R08: Gate closes at once on transmit high or receive low; reopening recounts.
// R09: Zero delay passes the short signal at all times.
// R10: Gated short high for length plus one ticks sets interrupt flag bit 3.
// R11: Reading the interrupt flag register clears the set bits.
// R12: With fault protection enabled, a detected short sets latched fault flag.
// R13: Fault flag shows in status bit 3.
// R14: Fault flag holds until config bit 5 is written with 1.
// R15: Override bit 1 defeats all forcing of the transmit line.
// R16: The low-power state forces the transmit line high.
// R17: Software keeps the override clear in normal operation.
// R18: Config bit 0 drives the slew-rate bypass control.
// R19: Debounce length resets to 0F.
// R20: Gate delay resets to 4F.
// R21: Outside full power the transmit line is forced high unless overridden.
// R22: Transmit out is MCU transmit OR force condition, force gated by override.
// R23: Clear strobes act one cycle and read back as zero.
module ltp_txd_protect #(
    parameter int unsigned TIMEOUT_CYC = (`LTP_TIMEOUT_US * `LTP_CLK_MHZ)
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mcu_txd,
    input wire logic phy_rxd,
    input wire logic phy_short,
    input wire logic full_power_state,
    output logic phy_txd,
    output logic slew_bypass_enable
);
    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] txd_s_q, rxd_s_q, sht_s_q, fullpwr_s_q;
    logic txd_i, rxd_i, sht_i, fullpwr_i;

    // Two flops on every asynchronous input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txd_s_q <= 2'h3;
            rxd_s_q <= 2'h3;
            sht_s_q <= 2'h0;
            fullpwr_s_q <= 2'h0;
        end
        else
        begin
            txd_s_q <= {txd_s_q[0], mcu_txd};
            rxd_s_q <= {rxd_s_q[0], phy_rxd};
            sht_s_q <= {sht_s_q[0], phy_short};
            fullpwr_s_q <= {fullpwr_s_q[0], full_power_state};
        end
    end
    assign txd_i = txd_s_q[1];
    assign rxd_i = rxd_s_q[1];
    assign sht_i = sht_s_q[1];
    assign fullpwr_i = fullpwr_s_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and APB decode
    ltp_pkg::ltp_byte_t cfg_q, filt_q, dly_q;
    logic stuck_low_latched_q, bus_fault_latched_q;
    logic [1:0] interrupt_flags_q;
    logic wr_en, rd_en, hit;
    logic stuck_flag_clear, fault_flag_clear;
    logic stuck_evt, fault_evt;
    logic [31:0] rdata_d;
    logic [7:0] idx;
    logic aligned;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `LTP_OFF_CFG) || (a == `LTP_OFF_FILT) || (a == `LTP_OFF_DLY)
            || (a == `LTP_OFF_STAT) || (a == `LTP_OFF_IRQ);
    endfunction

    // Register index is the byte address over four; only whole words decode
    assign idx = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'h0);

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign hit = aligned && is_mapped(idx);
    assign pslverr = psel && penable && !hit;
    assign wr_en = psel && penable && pwrite && hit;
    assign rd_en = psel && penable && !pwrite && hit;
    assign stuck_flag_clear = wr_en && (idx == `LTP_OFF_CFG)
        && pwdata[`LTP_BIT_CLR_STUCK]; // R06 R23
    assign fault_flag_clear = wr_en && (idx == `LTP_OFF_CFG)
        && pwdata[`LTP_BIT_CLR_FAULT]; // R14 R23

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= 8'h00;
            filt_q <= `LTP_FILT_RST; // R19
            dly_q <= `LTP_DLY_RST; // R20
        end
        else if (wr_en)
        begin
            if (idx == `LTP_OFF_CFG)
                cfg_q <= pwdata[7:0] & `LTP_CFG_MASK;
            if (idx == `LTP_OFF_FILT)
                filt_q <= pwdata[7:0];
            if (idx == `LTP_OFF_DLY)
                dly_q <= pwdata[7:0];
        end
    end
    assign slew_bypass_enable = cfg_q[`LTP_BIT_SLEW]; // R18

    // Read mux; strobes, unmapped and unaligned addresses read as zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (hit)
        begin
            unique case (idx)
                `LTP_OFF_CFG: rdata_d[7:0] = cfg_q; // R23
                `LTP_OFF_FILT: rdata_d[7:0] = filt_q;
                `LTP_OFF_DLY: rdata_d[7:0] = dly_q;
                `LTP_OFF_STAT:
                begin
                    rdata_d[`LTP_BIT_STUCK] = stuck_low_latched_q; // R05
                    rdata_d[`LTP_BIT_FAULT] = bus_fault_latched_q; // R13
                end
                `LTP_OFF_IRQ:
                begin
                    rdata_d[`LTP_BIT_STUCK] = interrupt_flags_q[0];
                    rdata_d[`LTP_BIT_FAULT] = interrupt_flags_q[1];
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end
    assign prdata = rdata_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Stuck-low timeout
    logic [$clog2(TIMEOUT_CYC+1)-1:0] to_cnt_q;

    // Counts while transmit low in full power; fires once at the limit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            to_cnt_q <= '0;
        else if (!fullpwr_i || txd_i) // R01
            to_cnt_q <= '0;
        else if (to_cnt_q != TIMEOUT_CYC[$bits(to_cnt_q)-1:0])
            to_cnt_q <= to_cnt_q + 1'b1; // R03
    end
    assign stuck_evt = fullpwr_i && !txd_i
        && (to_cnt_q == TIMEOUT_CYC[$bits(to_cnt_q)-1:0] - 1'b1); // R03

    ////////////////////////////////////////////////////////////////////////////////
    // 4 MHz tick, phase accumulator on the 10 MHz clock, ticks alternately 2 and 3 cycles apart
    logic [3:0] acc_q;
    logic tick;
    logic [4:0] acc_sum;
    assign acc_sum = {1'b0, acc_q} + 5'(`LTP_SLOW_MHZ);
    assign tick = acc_sum >= 5'(`LTP_CLK_MHZ);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_q <= 4'h0;
        else if (tick)
            acc_q <= 4'(acc_sum - 5'(`LTP_CLK_MHZ));
        else
            acc_q <= acc_sum[3:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Short gate and debounce
    logic [7:0] gate_cnt_q;
    logic [8:0] deb_cnt_q;
    logic gate_open, gated_short, gate_prime;

    // Counts while transmit low and receive high; any break restarts
    assign gate_prime = !phy_txd && rxd_i;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gate_cnt_q <= 8'h00;
        else if (!gate_prime)
            gate_cnt_q <= 8'h00; // R08
        else if (tick && gate_cnt_q != dly_q)
            gate_cnt_q <= gate_cnt_q + 8'h01; // R07
    end
    assign gate_open = (dly_q == 8'h00) || (gate_prime && gate_cnt_q == dly_q); // R07 R08 R09
    assign gated_short = sht_i && gate_open;

    // High-time counter, saturates after firing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            deb_cnt_q <= 9'h000;
        else if (!gated_short)
            deb_cnt_q <= 9'h000;
        else if (tick && deb_cnt_q <= {1'b0, filt_q})
            deb_cnt_q <= deb_cnt_q + 9'h001;
    end
    assign fault_evt = tick && gated_short && deb_cnt_q == {1'b0, filt_q}; // R10

    ////////////////////////////////////////////////////////////////////////////////
    // Flags; a new event wins over a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stuck_low_latched_q <= 1'b0;
        else if (stuck_evt)
            stuck_low_latched_q <= 1'b1; // R04
        else if (stuck_flag_clear)
            stuck_low_latched_q <= 1'b0; // R06
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bus_fault_latched_q <= 1'b0;
        else if (fault_evt && cfg_q[`LTP_BIT_FPEN])
            bus_fault_latched_q <= 1'b1; // R12
        else if (fault_flag_clear)
            bus_fault_latched_q <= 1'b0; // R14
    end

    // Interrupt flags clear on read, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interrupt_flags_q <= 2'h0;
        else
        begin
            if (stuck_evt)
                interrupt_flags_q[0] <= 1'b1; // R04
            else if (rd_en && idx == `LTP_OFF_IRQ)
                interrupt_flags_q[0] <= 1'b0; // R11
            if (fault_evt)
                interrupt_flags_q[1] <= 1'b1; // R10
            else if (rd_en && idx == `LTP_OFF_IRQ)
                interrupt_flags_q[1] <= 1'b0; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit output, registered
    logic force_hi;
    assign force_hi = (stuck_low_latched_q || bus_fault_latched_q || !fullpwr_i)
        && !cfg_q[`LTP_BIT_OVR]; // R15 R16 R21
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phy_txd <= 1'b1;
        else
            phy_txd <= txd_i || force_hi; // R22
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    stuck_forces_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        stuck_low_latched_q && !cfg_q[`LTP_BIT_OVR] |=> phy_txd)
        else $error("stuck flag did not force transmit high");
    lowpower_forces_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
        !fullpwr_i && !cfg_q[`LTP_BIT_OVR] |=> phy_txd)
        else $error("low power did not force transmit high");
    override_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
        cfg_q[`LTP_BIT_OVR] |=> phy_txd == $past(txd_i))
        else $error("override did not pass transmit");
    txd_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
        !force_hi |=> phy_txd == $past(txd_i))
        else $error("unforced transmit did not follow input");
    stuck_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        stuck_flag_clear && !stuck_evt |=> !stuck_low_latched_q)
        else $error("stuck flag not cleared");
    timeout_once_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        stuck_evt |=> !stuck_evt)
        else $error("timeout fired twice in a row");
    fault_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
        bus_fault_latched_q && !fault_flag_clear |=> bus_fault_latched_q)
        else $error("fault flag dropped without clear");
    fault_needs_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        $rose(bus_fault_latched_q) |-> $past(cfg_q[`LTP_BIT_FPEN]))
        else $error("fault flag set while protection disabled");
    fault_sets_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        fault_evt && cfg_q[`LTP_BIT_FPEN] |=> bus_fault_latched_q)
        else $error("detected short did not set fault flag");
    gate_closes_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
        dly_q != 8'h00 && (phy_txd || !rxd_i) |-> !gate_open)
        else $error("gate open with transmit high or receive low");
    zero_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
        dly_q == 8'h00 |-> gated_short == sht_i)
        else $error("zero delay gate not transparent");
    tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        tick |=> !tick)
        else $error("slow tick pulses back to back");
    short_sets_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        fault_evt |=> interrupt_flags_q[1])
        else $error("short did not set interrupt flag");
    irq_read_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        rd_en && idx == `LTP_OFF_IRQ && !stuck_evt && !fault_evt
        |=> interrupt_flags_q == 2'h0)
        else $error("interrupt flags not cleared by read");
    stuck_sets_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        stuck_evt |=> interrupt_flags_q[0] && stuck_low_latched_q)
        else $error("timeout did not set flags");
    stuck_fullpwr_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        !fullpwr_i |-> !stuck_evt)
        else $error("timeout outside full power");
    slew_out_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
        wr_en && idx == `LTP_OFF_CFG |=> slew_bypass_enable == $past(pwdata[`LTP_BIT_SLEW]))
        else $error("slew bypass did not take written value");
    strobe_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R23
        rd_en && idx == `LTP_OFF_CFG |-> prdata[`LTP_BIT_CLR_FAULT:`LTP_BIT_CLR_STUCK] == 2'h0)
        else $error("strobe bits read back nonzero");

    timeout_c: cover property (@(posedge pclk) disable iff (!presetn) stuck_evt);
    fault_c: cover property (@(posedge pclk) disable iff (!presetn)
        fault_evt && cfg_q[`LTP_BIT_FPEN]);
    gate_c: cover property (@(posedge pclk) disable iff (!presetn)
        dly_q != 8'h00 && gate_open);
    override_c: cover property (@(posedge pclk) disable iff (!presetn)
        cfg_q[`LTP_BIT_OVR] && stuck_low_latched_q);
    fault_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
        fault_flag_clear && bus_fault_latched_q);
endmodule

// *** ltp_defines.svh ***
// Constants for the transmit line protection block: register indices, fields, resets, timing.
// Assumes inclusion by bare name from the design file.
`ifndef LTP_DEFINES_SVH
`define LTP_DEFINES_SVH
`define LTP_OFF_CFG 8'hB4
`define LTP_OFF_FILT 8'hB5
`define LTP_OFF_DLY 8'hB6
`define LTP_OFF_STAT 8'hB8
`define LTP_OFF_IRQ 8'hBC
`define LTP_BIT_SLEW 0
`define LTP_BIT_OVR 1
`define LTP_BIT_FPEN 2
`define LTP_BIT_CLR_STUCK 4
`define LTP_BIT_CLR_FAULT 5
`define LTP_BIT_STUCK 2
`define LTP_BIT_FAULT 3
`define LTP_CFG_MASK 8'h07
`define LTP_FILT_RST 8'h0F
`define LTP_DLY_RST 8'h4F
`define LTP_TIMEOUT_US 10240
`define LTP_CLK_MHZ 10
`define LTP_SLOW_MHZ 4
`endif

// *** ltp_pkg.sv ***
// Types shared by the transmit line protection block.
// Assumes nothing beyond a SystemVerilog compiler.
package ltp_pkg;
    typedef logic [7:0] ltp_byte_t;
endpackage

// *** ltp_far_model.sv ***
// Far-side model: MCU transmit output and transceiver receive and short outputs.
// Assumes the bench commands transmit level, a bus held recessive and a short.
module ltp_far_model (
    input wire logic pclk,
    input wire logic tx_cmd,
    input wire logic stuck_cmd,
    input wire logic short_cmd,
    input wire logic phy_txd,
    output logic mcu_txd,
    output logic phy_rxd,
    output logic phy_short
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle recessive, no short at time zero
    initial
    begin
        mcu_txd = 1'b1;
        phy_rxd = 1'b1;
        phy_short = 1'b0;
    end

    // Transmit follows the command; long lows only when the bench asks
    always @(posedge pclk)
    begin
        mcu_txd <= tx_cmd;
        phy_rxd <= stuck_cmd | phy_txd; // Bus loopback, held high by the stuck command
        phy_short <= short_cmd;
    end
endmodule

// *** tb_top.sv ***
// Testbench for the transmit line protection block.
// Assumes the far-side model and zero-wait APB answers.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk, presetn, psel, penable, pwrite, full_pwr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, mcu_txd, phy_rxd, phy_short, phy_txd, slew;
    logic tx_cmd, stuck_cmd, short_cmd;
    int fails, total_checks;

    ltp_txd_protect #(.TIMEOUT_CYC(200)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mcu_txd(mcu_txd), .phy_rxd(phy_rxd),
        .phy_short(phy_short), .full_power_state(full_pwr), .phy_txd(phy_txd),
        .slew_bypass_enable(slew));
    ltp_far_model far_u (.pclk(pclk), .tx_cmd(tx_cmd), .stuck_cmd(stuck_cmd),
        .short_cmd(short_cmd), .phy_txd(phy_txd), .mcu_txd(mcu_txd), .phy_rxd(phy_rxd),
        .phy_short(phy_short));

    // Clock at 10 MHz
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // APB transfer: setup, access until pready, then release; a is the register index
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {a, 2'h0}; // Byte address is four times the index
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        check("pready", 32'h0000_0001, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check("write pslverr", 32'h0000_0000, {31'h0, e});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check("prdata", exp, r);
        check("pslverr", {31'h0, err_exp}, {31'h0, e});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_and_slew();
        rd(8'hB4, 32'h0000_0000, 1'b0);
        rd(8'hB5, 32'h0000_000F, 1'b0);
        rd(8'hB6, 32'h0000_004F, 1'b0);
        rd(8'hB7, 32'h0000_0000, 1'b1);
        wr(8'hB4, 32'h0000_0001);
        wait_cyc(2);
        check("slew", 32'h1, {31'h0, slew});
        wr(8'hB4, 32'h0000_0000);
    endtask

    task automatic t_power_override();
        tx_cmd <= 1'b0;
        wait_cyc(6);
        check("phy_txd low power", 32'h1, {31'h0, phy_txd});
        wr(8'hB4, 32'h0000_0002);
        wait_cyc(5);
        check("phy_txd override", 32'h0, {31'h0, phy_txd});
        wr(8'hB4, 32'h0000_0000);
        wait_cyc(5);
        check("phy_txd forced", 32'h1, {31'h0, phy_txd});
        full_pwr <= 1'b1;
        wait_cyc(6);
        check("phy_txd full power", 32'h0, {31'h0, phy_txd});
        tx_cmd <= 1'b1;
        wait_cyc(5);
        check("phy_txd released", 32'h1, {31'h0, phy_txd});
    endtask

    task automatic t_gate_delay();
        wr(8'hB6, 32'h0000_0005);
        wr(8'hB5, 32'h0000_0000);
        short_cmd <= 1'b1;
        wait_cyc(50);
        rd(8'hBC, 32'h0000_0000, 1'b0);
        tx_cmd <= 1'b0;
        wait_cyc(50);
        rd(8'hBC, 32'h0000_0000, 1'b0);
        stuck_cmd <= 1'b1;
        wait_cyc(6);
        rd(8'hBC, 32'h0000_0000, 1'b0);
        wait_cyc(40);
        rd(8'hBC, 32'h0000_0008, 1'b0);
        rd(8'hB8, 32'h0000_0000, 1'b0);
        tx_cmd <= 1'b1;
        stuck_cmd <= 1'b0;
        short_cmd <= 1'b0;
    endtask

    task automatic t_short_latch();
        wr(8'hB6, 32'h0000_0000);
        wr(8'hB5, 32'h0000_0003);
        wr(8'hB4, 32'h0000_0004);
        rd(8'hBC, 32'h0000_0000, 1'b0);
        short_cmd <= 1'b1;
        wait_cyc(30);
        rd(8'hBC, 32'h0000_0008, 1'b0);
        rd(8'hB8, 32'h0000_0008, 1'b0);
        check("phy_txd short forced", 32'h1, {31'h0, phy_txd});
        short_cmd <= 1'b0;
        wait_cyc(5);
        rd(8'hB8, 32'h0000_0008, 1'b0);
        wr(8'hB4, 32'h0000_0024);
        rd(8'hB8, 32'h0000_0000, 1'b0);
        rd(8'hB4, 32'h0000_0004, 1'b0);
        wr(8'hB4, 32'h0000_0000);
    endtask

    task automatic t_timeout();
        tx_cmd <= 1'b0;
        wait_cyc(150);
        rd(8'hB8, 32'h0000_0000, 1'b0);
        wait_cyc(80);
        rd(8'hBC, 32'h0000_0004, 1'b0);
        check("phy_txd stuck forced", 32'h1, {31'h0, phy_txd});
        rd(8'hBC, 32'h0000_0000, 1'b0);
        rd(8'hB8, 32'h0000_0004, 1'b0);
        wr(8'hB4, 32'h0000_0002);
        wait_cyc(5);
        check("phy_txd stuck override", 32'h0, {31'h0, phy_txd});
        tx_cmd <= 1'b1;
        wr(8'hB4, 32'h0000_0010);
        rd(8'hB8, 32'h0000_0000, 1'b0);
        rd(8'hB4, 32'h0000_0000, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        fails = 0;
        total_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0000_0000;
        full_pwr = 1'b0;
        tx_cmd = 1'b1;
        stuck_cmd = 1'b0;
        short_cmd = 1'b0;
        wait_cyc(2);
        presetn <= 1'b1;
        t_reset_and_slew();
        t_power_override();
        t_gate_delay();
        t_short_latch();
        t_timeout();
        close_out();
    end

    // Watchdog against a hung bus or scenario
    initial
    begin
        wait_cyc(20000);
        fails++;
        close_out();
    end
endmodule
